// [hw/pot_core_pkg.sv]
package pot_core_pkg;
  // frame layout
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned BIT_CNT_W      = 3;
  localparam logic [3:0]  DEVICE_TYPE_ID = 4'h6; // arbitrary neutral value
  localparam logic [1:0]  ADDR_PAD       = 2'h0;
  localparam int unsigned POT_COUNT      = 4;
  localparam int unsigned SLOT_COUNT     = 4;
  localparam logic [1:0]  POWER_UP_SLOT  = 2'h0;
  localparam logic [7:0]  WIPER_MAX      = 8'hff;
  localparam logic [7:0]  WIPER_MIN      = 8'h00;
  localparam logic [7:0]  SLOT_RESET     = 8'h80;

  // opcode_bits encodings
  localparam logic [3:0] OP_RD_WIPER   = 4'h9;
  localparam logic [3:0] OP_WR_WIPER   = 4'ha;
  localparam logic [3:0] OP_RD_SLOT    = 4'hb;
  localparam logic [3:0] OP_WR_SLOT    = 4'hc;
  localparam logic [3:0] OP_SLOT2WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER2SLOT = 4'he;
  localparam logic [3:0] OP_GSLOT2WIP  = 4'h1;
  localparam logic [3:0] OP_GWIP2SLOT  = 4'h8;
  localparam logic [3:0] OP_INCDEC     = 4'h2;
  localparam logic [3:0] OP_RD_STATUS  = 4'h4;

  // times
  localparam int unsigned CLK_MHZ               = 200;
  localparam int unsigned NONVOLATILE_WRITE_MS  = 5;
  localparam int unsigned WIPER_SETTLE_MIN_US   = 5;
  localparam int unsigned WIPER_SETTLE_MAX_US   = 10;
  localparam int unsigned NONVOLATILE_WRITE_CYC = NONVOLATILE_WRITE_MS * 1000 * CLK_MHZ;
  localparam int unsigned WIPER_SETTLE_CYC      = WIPER_SETTLE_MIN_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_ADDR  = 3'b000,
    ST_INSTR = 3'b001,
    ST_DATA  = 3'b010,
    ST_INCDEC= 3'b011,
    ST_IGNORE= 3'b100,
    ST_DONE  = 3'b101
  } frame_state_t;
endpackage

// [hw/wiper_settle.sv]
`timescale 1ns/10ps
// delays the tap selection by a fixed settle time after each change
module wiper_settle #(
  parameter int unsigned SETTLE_CYC = pot_core_pkg::WIPER_SETTLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] wiper_in,
  output logic      [7:0] tap_out
);
  typedef struct packed {
    logic [7:0]  last;
    logic [7:0]  tap;
    logic [15:0] cnt;
  } settle_t;

  settle_t s_r;
  settle_t s_nxt;

  // restart the settle count on any change, then copy
  always_comb begin
    s_nxt = s_r;
    if (wiper_in != s_r.last) begin
      s_nxt.last = wiper_in;
      s_nxt.cnt  = 16'(SETTLE_CYC);
    end else if (s_r.cnt > 16'h0001) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end else if (s_r.cnt == 16'h0001) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.tap = s_r.last;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tap_out = s_r.tap;
endmodule

// [hw/quad_pot_serial_command_core.sv]
`timescale 1ns/10ps
// Functional notes
// - address byte first; upper nibble must equal the device type identifier
// - continue only when address bits 1:0 match the board address pins
// - second byte is the instruction; upper nibble is the opcode
// - instruction bits 1:0 select one of four wipers
// - instruction bits 3:2 select one of four setting slots
// - each pot has an 8-bit wiper decoded to one-of-256 taps
// - wiper changes only by write, slot copy, step, or power-up load
// - power-up loads each wiper from its slot zero
// - wipers are volatile; after power-up they hold slot zero
// - four 8-bit stored slots per pot, readable, writable, copyable
// - a slot change is a nonvolatile write finishing within 5 ms
// - slot commit starts when chip select rises after a write
// - write pending flag readable through the status command
// - wiper tap follows a change within 5 to 10 us
// - step command: clock with data high steps up, low steps down
// - write pending reads one during nonvolatile write, else zero
module quad_pot_serial_command_core #(
  parameter int unsigned NV_WRITE_CYC = pot_core_pkg::NONVOLATILE_WRITE_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  input  wire logic        board_address_pin_high,
  input  wire logic        board_address_pin_low,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             write_pending_flag,
  output logic [7:0]       tap_0,
  output logic [7:0]       tap_1,
  output logic [7:0]       tap_2,
  output logic [7:0]       tap_3,
  output logic [1023:0]    tap_select
);
  localparam int unsigned NPOT = pot_core_pkg::POT_COUNT;
  localparam int unsigned NSLT = pot_core_pkg::SLOT_COUNT;

  typedef struct packed {
    logic [1:0]                 sck_s;
    logic [1:0]                 cs_s;
    logic [1:0]                 sdi_s;
    logic [1:0]                 addr_hi_s;
    logic [1:0]                 addr_lo_s;
    logic                       sck_d;
    pot_core_pkg::frame_state_t st;
    logic [2:0]                 bitn;
    logic [7:0]                 shift;
    logic [7:0]                 instr;
    logic [7:0]                 tx;
    logic                       tx_en;
    logic                       sdo;
    logic                       sdo_oe;
    logic                       pend_commit;
    logic [1:0]                 pend_pot;
    logic [1:0]                 pend_slot;
    logic                       pend_all;
    logic [7:0]                 pend_val;
    logic                       nv_busy;
    logic [31:0]                nv_cnt;
    logic                       powered;
    logic [NPOT-1:0][7:0]       wiper;
  } core_t;

  core_t c_r;
  core_t c_nxt;

  // nonvolatile slot array, reset stands for the factory contents
  logic [7:0] slot_r [NPOT][NSLT];
  logic       slot_we;
  logic [1:0] slot_we_pot;
  logic [1:0] slot_we_slot;
  logic       slot_we_all;
  logic [7:0] slot_we_val;

  // saturating single step
  function automatic logic [7:0] step(input logic [7:0] v, input logic up);
    if (up) begin
      step = (v == pot_core_pkg::WIPER_MAX) ? v : v + 8'h01;
    end else begin
      step = (v == pot_core_pkg::WIPER_MIN) ? v : v - 8'h01;
    end
  endfunction

  // one-of-256 decode of a wiper value
  function automatic logic [255:0] onehot(input logic [7:0] v);
    onehot    = '0;
    onehot[v] = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // frame decode and command execution
  always_comb begin
    logic       rise;
    logic       fall;
    logic       cs_act;
    logic [7:0] byte_in;
    logic [3:0] op;
    logic [1:0] pot;
    logic [1:0] slt;
    rise    = 1'b0;
    fall    = 1'b0;
    cs_act  = 1'b0;
    byte_in = '0;
    op      = '0;
    pot     = '0;
    slt     = '0;
    c_nxt   = c_r;
    slot_we      = 1'b0;
    slot_we_pot  = '0;
    slot_we_slot = '0;
    slot_we_all  = 1'b0;
    slot_we_val  = '0;

    c_nxt.sck_s = {c_r.sck_s[0], sck};
    c_nxt.cs_s  = {c_r.cs_s[0], cs_n};
    c_nxt.sdi_s = {c_r.sdi_s[0], sdi};
    c_nxt.addr_hi_s = {c_r.addr_hi_s[0], board_address_pin_high};
    c_nxt.addr_lo_s = {c_r.addr_lo_s[0], board_address_pin_low};
    c_nxt.sck_d = c_r.sck_s[1];
    rise   = c_r.sck_s[1] & ~c_r.sck_d;
    fall   = ~c_r.sck_s[1] & c_r.sck_d;
    cs_act = ~c_r.cs_s[1];
    byte_in = {c_r.shift[6:0], c_r.sdi_s[1]};
    op  = c_r.instr[7:4];
    pot = c_r.instr[1:0];
    slt = c_r.instr[3:2];

    // power-up load of every wiper from slot zero
    if (!c_r.powered) begin
      c_nxt.powered = 1'b1;
      for (int p = 0; p < NPOT; p++) begin
        c_nxt.wiper[p] = slot_r[p][pot_core_pkg::POWER_UP_SLOT];
      end
    end

    // nonvolatile write timer
    if (c_r.nv_busy) begin
      if (c_r.nv_cnt <= 32'h1) begin
        c_nxt.nv_busy = 1'b0;
        c_nxt.nv_cnt  = '0;
      end else begin
        c_nxt.nv_cnt = c_r.nv_cnt - 32'h1;
      end
    end

    if (!cs_act) begin
      // deselect: commit a pending slot write and rearm the frame
      c_nxt.st     = pot_core_pkg::ST_ADDR;
      c_nxt.bitn   = '0;
      c_nxt.sdo_oe = 1'b0;
      c_nxt.tx_en  = 1'b0;
      if (c_r.pend_commit) begin
        c_nxt.pend_commit = 1'b0;
        c_nxt.nv_busy     = 1'b1;
        c_nxt.nv_cnt      = NV_WRITE_CYC;
        slot_we      = 1'b1;
        slot_we_pot  = c_r.pend_pot;
        slot_we_slot = c_r.pend_slot;
        slot_we_all  = c_r.pend_all;
        slot_we_val  = c_r.pend_val;
      end
    end else if (c_r.powered) begin
      // drive the next output bit on the falling serial clock edge
      if (fall && c_r.tx_en) begin
        c_nxt.sdo_oe = 1'b1;
        c_nxt.sdo    = c_r.tx[7];
        c_nxt.tx     = {c_r.tx[6:0], 1'b0};
      end
      if (rise) begin
        c_nxt.shift = byte_in;
        c_nxt.bitn  = c_r.bitn + 3'h1;
        unique case (c_r.st)
          pot_core_pkg::ST_ADDR: begin
            if (c_r.bitn == 3'h7) begin
              if (byte_in[7:4] == pot_core_pkg::DEVICE_TYPE_ID &&
                  byte_in[1:0] == {c_r.addr_hi_s[1], c_r.addr_lo_s[1]}) begin
                c_nxt.st = pot_core_pkg::ST_INSTR;
              end else begin
                c_nxt.st = pot_core_pkg::ST_IGNORE;
              end
            end
          end
          pot_core_pkg::ST_INSTR: begin
            if (c_r.bitn == 3'h7) begin
              c_nxt.instr = byte_in;
              c_nxt.st    = pot_core_pkg::ST_DATA;
              c_nxt.tx_en = 1'b1;
              unique case (byte_in[7:4])
                pot_core_pkg::OP_RD_WIPER:  c_nxt.tx = c_r.wiper[byte_in[1:0]];
                pot_core_pkg::OP_RD_SLOT:   c_nxt.tx = slot_r[byte_in[1:0]][byte_in[3:2]];
                pot_core_pkg::OP_RD_STATUS: c_nxt.tx = {7'h00, c_r.nv_busy};
                pot_core_pkg::OP_WR_WIPER,
                pot_core_pkg::OP_WR_SLOT:   c_nxt.tx_en = 1'b0;
                pot_core_pkg::OP_INCDEC: begin
                  c_nxt.tx_en = 1'b0;
                  c_nxt.st    = pot_core_pkg::ST_INCDEC;
                end
                pot_core_pkg::OP_SLOT2WIPER: begin
                  c_nxt.tx_en = 1'b0;
                  c_nxt.st    = pot_core_pkg::ST_DONE;
                  c_nxt.wiper[byte_in[1:0]] = slot_r[byte_in[1:0]][byte_in[3:2]];
                end
                pot_core_pkg::OP_GSLOT2WIP: begin
                  c_nxt.tx_en = 1'b0;
                  c_nxt.st    = pot_core_pkg::ST_DONE;
                  for (int p = 0; p < NPOT; p++) begin
                    c_nxt.wiper[p] = slot_r[p][byte_in[3:2]];
                  end
                end
                pot_core_pkg::OP_WIPER2SLOT,
                pot_core_pkg::OP_GWIP2SLOT: begin
                  c_nxt.tx_en       = 1'b0;
                  c_nxt.st          = pot_core_pkg::ST_DONE;
                  c_nxt.pend_commit = 1'b1;
                  c_nxt.pend_pot    = byte_in[1:0];
                  c_nxt.pend_slot   = byte_in[3:2];
                  c_nxt.pend_all    = (byte_in[7:4] == pot_core_pkg::OP_GWIP2SLOT);
                  c_nxt.pend_val    = c_r.wiper[byte_in[1:0]];
                end
                default: begin
                  c_nxt.tx_en = 1'b0;
                  c_nxt.st    = pot_core_pkg::ST_IGNORE;
                end
              endcase
            end
          end
          pot_core_pkg::ST_DATA: begin
            if (c_r.bitn == 3'h7) begin
              c_nxt.st = pot_core_pkg::ST_DONE;
              if (op == pot_core_pkg::OP_WR_WIPER) begin
                c_nxt.wiper[pot] = byte_in;
              end
              if (op == pot_core_pkg::OP_WR_SLOT) begin
                c_nxt.pend_commit = 1'b1;
                c_nxt.pend_pot    = pot;
                c_nxt.pend_slot   = slt;
                c_nxt.pend_all    = 1'b0;
                c_nxt.pend_val    = byte_in;
              end
            end
          end
          pot_core_pkg::ST_INCDEC: begin
            c_nxt.wiper[pot] = step(c_r.wiper[pot], c_r.sdi_s[1]);
          end
          pot_core_pkg::ST_IGNORE,
          pot_core_pkg::ST_DONE: begin
            c_nxt.bitn = c_r.bitn;
          end
          default: c_nxt.st = pot_core_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c_r        <= '0;
      c_r.sck_s  <= 2'h0;
      c_r.cs_s   <= 2'h3;
      c_r.st     <= pot_core_pkg::ST_ADDR;
    end else begin
      c_r <= c_nxt;
    end
  end

  // slot storage; commit once chip select releases
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NPOT; p++) begin
        for (int s = 0; s < NSLT; s++) begin
          slot_r[p][s] <= pot_core_pkg::SLOT_RESET;
        end
      end
    end else if (slot_we) begin
      for (int p = 0; p < NPOT; p++) begin
        if (slot_we_all) begin
          slot_r[p][slot_we_slot] <= c_r.wiper[p];
        end else if (p == int'(slot_we_pot)) begin
          slot_r[p][slot_we_slot] <= slot_we_val;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tap outputs, each settled before it moves
  logic [NPOT-1:0][7:0] tap_w;
  logic [1023:0]        sel_r;

  for (genvar g = 0; g < NPOT; g++) begin : g_settle
    wiper_settle u_settle (
      .clk      (clk),
      .reset_n  (reset_n),
      .wiper_in (c_r.wiper[g]),
      .tap_out  (tap_w[g])
    );
  end

  // registered one-of-256 selections
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_r <= '0;
    end else begin
      sel_r <= {onehot(tap_w[3]), onehot(tap_w[2]), onehot(tap_w[1]), onehot(tap_w[0])};
    end
  end

  assign sdo                = c_r.sdo;
  assign sdo_oe             = c_r.sdo_oe;
  assign write_pending_flag = c_r.nv_busy;
  assign tap_0              = tap_w[0];
  assign tap_1              = tap_w[1];
  assign tap_2              = tap_w[2];
  assign tap_3              = tap_w[3];
  assign tap_select         = sel_r;
endmodule

// [bench/pot_core_chk.sv]
`timescale 1ns/10ps
// pin-level checks of the serial pot core
module pot_core_chk #(
  parameter int unsigned NV_WRITE_CYC = 200
) (
  input wire logic          clk,
  input wire logic          reset_n,
  input wire logic          cs_n,
  input wire logic          sdo_oe,
  input wire logic          write_pending_flag,
  input wire logic [7:0]    tap_0,
  input wire logic [7:0]    tap_2,
  input wire logic [7:0]    tap_3,
  input wire logic [1023:0] tap_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // cycles since reset release and length of the busy run
  int unsigned pu_r;
  int unsigned busy_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_r   <= 0;
      busy_r <= 0;
    end else begin
      pu_r   <= (pu_r < 5000) ? pu_r + 1 : pu_r;
      busy_r <= write_pending_flag ? busy_r + 1 : 0;
    end
  end
  ////////////////////////////////////////
  // output enable only inside a chip select frame
  AST_OE_DESELECT: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("output driven while deselected");
  AST_OE_IN_FRAME: assert property ($rose(sdo_oe) |-> !$past(cs_n, 4))
    else $error("output enabled outside a frame");
  // one-hot tap decode of the settled wiper
  AST_TAPSEL_POT0: assert property ($past(reset_n) |-> tap_select[255:0] == (256'h1 << $past(tap_0)))
    else $error("tap decode wrong");
  // busy flag window
  AST_NV_BOUND: assert property (write_pending_flag |-> busy_r <= NV_WRITE_CYC)
    else $error("write cycle too long");
  AST_COMMIT_AT_CS: assert property ($rose(write_pending_flag) |-> cs_n && $past(cs_n, 2))
    else $error("commit before deselect");
  AST_BUSY_HOLD: assert property ($rose(write_pending_flag) |=> write_pending_flag [*8])
    else $error("busy flag dropped early");
  // power-up load reaches the taps only after the settle time
  AST_TAP_HOLD: assert property (pu_r < 990 |-> tap_0 == 8'h00 && tap_3 == 8'h00)
    else $error("tap moved before settle time");
  AST_TAP_LOAD: assert property (pu_r == 1020 |-> tap_0 == pot_core_pkg::SLOT_RESET && tap_2 == tap_0)
    else $error("tap not loaded from slot zero");
endmodule
bind quad_pot_serial_command_core pot_core_chk #(.NV_WRITE_CYC(NV_WRITE_CYC)) chk (
  .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sdo_oe(sdo_oe), .write_pending_flag(write_pending_flag),
  .tap_0(tap_0), .tap_2(tap_2), .tap_3(tap_3), .tap_select(tap_select));

// [bench/spi_master_model.sv]
`timescale 1ns/10ps
// serial bus master; clock idles low outside frames
module spi_master_model (
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [7:0] rx_byte;
  logic       oe_seen;
  event       rx_done;
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  ////////////////////////////////////////
  // n bits msb first, 80 ns a bit, reply shifted in on each rise
  task automatic frame(input logic [23:0] tx, input int n);
    oe_seen = 1'b0;
    cs_n    = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #40 sck = 1'b1;
      rx_byte = {rx_byte[6:0], sdo_oe ? sdo : ~sdo}; // released line shows the inverse
      oe_seen = oe_seen | sdo_oe;
      #40 sck = 1'b0;
    end
    sdi = ~sdi; // released line
    #80 cs_n = 1'b1;
    #160 -> rx_done;
  endtask
endmodule

// [bench/quad_pot_serial_command_core_tb.sv]
`timescale 1ns/10ps
module quad_pot_serial_command_core_tb;
  localparam int unsigned NV_CYC = 2000;
  logic          clk;
  logic          reset_n;
  logic          a_hi;
  logic          a_lo;
  logic          sck;
  logic          cs_n;
  logic          sdi;
  logic          sdo;
  logic          sdo_oe;
  logic          flag;
  logic [7:0]    tap [4];
  logic [1023:0] tap_select;
  logic [7:0]    ab;
  logic [8:0]    exp_q [$];
  logic [7:0]    v [4];
  logic [7:0]    d [4];
  int            failures;
  int            tests_run;
  quad_pot_serial_command_core #(.NV_WRITE_CYC(NV_CYC)) uut (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .sdi(sdi), .board_address_pin_high(a_hi),
    .board_address_pin_low(a_lo), .sdo(sdo), .sdo_oe(sdo_oe), .write_pending_flag(flag), .tap_0(tap[0]),
    .tap_1(tap[1]), .tap_2(tap[2]), .tap_3(tap[3]), .tap_select(tap_select));
  spi_master_model m (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  assign ab = {pot_core_pkg::DEVICE_TYPE_ID, pot_core_pkg::ADDR_PAD, a_hi, a_lo};
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  // compare, frame and register tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] dt, input int n,
                     input logic [8:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    #1;
    m.frame({a, ins, dt} >> (24 - n), n);
  endtask
  task automatic rd(input logic [3:0] op, input logic [1:0] s, input logic [1:0] p, input logic [7:0] e);
    cmd(ab, {op, s, p}, 8'h00, 24, {1'b1, e});
  endtask
  task automatic wr(input logic [3:0] op, input logic [1:0] s, input logic [1:0] p, input logic [7:0] dt);
    cmd(ab, {op, s, p}, dt, 24, 9'h000);
  endtask
  task automatic idle();
    for (int i = 0; i < NV_CYC + 500 && flag !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // compares each finished read frame with the oldest note
  initial begin
    logic [8:0] e;
    forever begin
      @(m.rx_done);
      e = exp_q.pop_front();
      if (e[8] !== 1'b0) check(m.rx_byte, e[7:0]);
    end
  end
  // watchdog
  initial begin
    #500us;
    failures++;
    report_and_stop();
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    failures = 0;
    tests_run = 0;
    void'($urandom(98));
    {a_hi, a_lo} = 2'($urandom);
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (20) @(posedge clk);
    for (int p = 0; p < 4; p++) rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'(p), pot_core_pkg::SLOT_RESET);
    for (int p = 0; p < 4; p++) begin
      v[p] = 8'($urandom);
      wr(pot_core_pkg::OP_WR_WIPER, 2'h0, 2'(p), v[p]);
    end
    repeat (900) @(posedge clk);
    #1;
    check(tap[3], pot_core_pkg::SLOT_RESET);
    repeat (1000) @(posedge clk);
    #1;
    for (int p = 0; p < 4; p++) begin
      check(tap[p], v[p]);
      check({7'h0, tap_select[256 * p + v[p]]}, 8'h01);
      rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'(p), v[p]);
    end
    // slot writes commit at deselect and raise the busy flag
    for (int s = 0; s < 4; s++) begin
      d[s] = 8'($urandom);
      wr(pot_core_pkg::OP_WR_SLOT, 2'(s), 2'h1, d[s]);
      check({7'h0, flag}, 8'h01);
      rd(pot_core_pkg::OP_RD_STATUS, 2'h0, 2'h1, 8'h01);
      idle();
      check({7'h0, flag}, 8'h00);
      rd(pot_core_pkg::OP_RD_STATUS, 2'h0, 2'h1, 8'h00);
    end
    for (int s = 0; s < 4; s++) rd(pot_core_pkg::OP_RD_SLOT, 2'(s), 2'h1, d[s]);
    // single and global copies
    cmd(ab, {pot_core_pkg::OP_SLOT2WIPER, 2'h2, 2'h1}, 8'h00, 16, 9'h000);
    rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h1, d[2]);
    cmd(ab, {pot_core_pkg::OP_WIPER2SLOT, 2'h3, 2'h0}, 8'h00, 16, 9'h000);
    idle();
    rd(pot_core_pkg::OP_RD_SLOT, 2'h3, 2'h0, v[0]);
    cmd(ab, {pot_core_pkg::OP_GSLOT2WIP, 2'h0, 2'h0}, 8'h00, 16, 9'h000);
    rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h1, d[0]);
    rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h3, pot_core_pkg::SLOT_RESET);
    cmd(ab, {pot_core_pkg::OP_GWIP2SLOT, 2'h2, 2'h0}, 8'h00, 16, 9'h000);
    idle();
    rd(pot_core_pkg::OP_RD_SLOT, 2'h2, 2'h1, d[0]);
    // steps up into the top end, then down
    wr(pot_core_pkg::OP_WR_WIPER, 2'h0, 2'h2, 8'hfe);
    cmd(ab, {pot_core_pkg::OP_INCDEC, 2'h0, 2'h2}, 8'he0, 21, 9'h000);
    rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h2, 8'hfd);
    // other board address or device type is ignored
    cmd(ab ^ 8'h01, {pot_core_pkg::OP_WR_WIPER, 2'h0, 2'h1}, 8'h11, 24, 9'h000);
    cmd(ab ^ 8'h40, {pot_core_pkg::OP_WR_WIPER, 2'h0, 2'h1}, 8'h22, 24, 9'h000);
    cmd(ab ^ 8'h02, {pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h1}, 8'h00, 24, 9'h000);
    check({7'h0, m.oe_seen}, 8'h00);
    // unknown opcode is ignored and never drives the output
    cmd(ab, {4'h7, 2'h0, 2'h1}, 8'h00, 24, 9'h000);
    check({7'h0, m.oe_seen}, 8'h00);
    rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h1, d[0]);
    // wipers do not survive a reset
    wr(pot_core_pkg::OP_WR_WIPER, 2'h0, 2'h3, 8'h3c);
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (20) @(posedge clk);
    rd(pot_core_pkg::OP_RD_WIPER, 2'h0, 2'h3, pot_core_pkg::SLOT_RESET);
    repeat (5) @(posedge clk);
    report_and_stop();
  end
endmodule
